// ==== core/pgst_pkg.sv ====
// shared constants for the pattern generator self-test block
package pgst_pkg;
	// ***************************************************************
	// register map (byte offsets, one 32-bit word each)
	// ***************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_LOOP_LO = 8'h08;
	localparam logic [7:0] OFS_LOOP_HI = 8'h0c;
	localparam logic [7:0] OFS_CLOCK = 8'h10;
	localparam logic [7:0] OFS_SIMPLE = 8'h14;
	localparam logic [7:0] OFS_PERSIST = 8'h18;
	localparam logic [7:0] OFS_MARCH = 8'h1c;
	localparam logic [7:0] OFS_PAUSE = 8'h20;
	localparam logic [7:0] OFS_DECODE = 8'h24;
	// control and status fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_SEL_LSB = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_PASS_BIT = 2;
	localparam int STAT_FAIL_LSB = 4;
	localparam logic [2:0] RST_SEL = 3'h0;
	// test selection codes
	localparam logic [2:0] T_LOOP = 3'h0;
	localparam logic [2:0] T_CLOCK = 3'h1;
	localparam logic [2:0] T_SIMPLE = 3'h2;
	localparam logic [2:0] T_PERSIST = 3'h3;
	localparam logic [2:0] T_MARCH = 3'h4;
	localparam logic [2:0] T_PAUSE = 3'h5;
	localparam logic [2:0] T_DECODE = 3'h6;
	localparam logic [2:0] T_ALL = 3'h7;
	// ***************************************************************
	// timing
	// ***************************************************************
	localparam int CLK_NS = 4;
	localparam int SETTLE_NS = 2000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int PERSIST_MS = 100;
	localparam int PERSIST_CYC = PERSIST_MS * 1000000 / CLK_NS;
	localparam int MARCH_PASSES = 5;
	// ***************************************************************
	// patterns and result codes
	// ***************************************************************
	localparam logic [7:0] PAT_ZERO = 8'h00;
	localparam logic [7:0] PAT_ONE = 8'hff;
	localparam logic [7:0] PAT_ALT = 8'h55;
	localparam logic [7:0] PAT_PERSIST = 8'ha5;
	localparam logic [7:0] PAT_WALK = 8'h01;
	localparam logic [23:0] LOOP_ADDR = 24'h000000;
	localparam logic [3:0] CLK_NO_RUN = 4'h1;
	localparam logic [3:0] CLK_NO_STOP = 4'h2;
	localparam logic [3:0] PSE_BRK_NONE = 4'h1;
	localparam logic [3:0] PSE_NOEVENT = 4'h2;
	localparam logic [3:0] PSE_ANY = 4'h3;
	localparam logic [3:0] DEC_NO_BREAK = 4'h1;
	localparam logic [3:0] DEC_NO_SWSTOP = 4'h2;
	localparam logic [3:0] DEC_NO_BRKSTOP = 4'h4;
	localparam logic [3:0] DEC_OTHER = 4'h8;
	// pause pattern modes and stop kinds
	localparam logic [1:0] PM_NONE = 2'h0;
	localparam logic [1:0] PM_NOEVENT = 2'h1;
	localparam logic [1:0] PM_ANY = 2'h2;
	localparam logic STOP_HALT = 1'b0;
	localparam logic STOP_BREAK = 1'b1;
endpackage

// ==== core/pgst_run_probe.sv ====
// run, sample, stop and sample again against the module run/halt control
module pgst_run_probe (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// request
	input wire logic start,
	input wire logic stop_kind,
	// run/halt control of the module
	output logic run_cmd,
	output logic halt_cmd,
	output logic break_cmd,
	input wire logic module_running,
	input wire logic stopped_by_break,
	// result
	output logic done,
	output logic run1,
	output logic run2,
	output logic by_brk
);
	typedef enum logic [2:0] {P_IDLE, P_WAIT1, P_WAIT2, P_DONE} pgst_prb_t;
	localparam logic [15:0] SETTLE = 16'(pgst_pkg::SETTLE_CYC);

	pgst_prb_t state;
	logic [15:0] cnt;
	logic run_s0, run_s1, brk_s0, brk_s1;
	logic kind;

	// status pins come from another domain, two flops first
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			run_s0 <= 1'b0;
			run_s1 <= 1'b0;
			brk_s0 <= 1'b0;
			brk_s1 <= 1'b0;
		end else begin
			run_s0 <= module_running;
			run_s1 <= run_s0;
			brk_s0 <= stopped_by_break;
			brk_s1 <= brk_s0;
		end
	end

	// sequence: run, settle, sample, stop, settle, sample
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= P_IDLE;
			cnt <= 16'h0000;
			kind <= 1'b0;
			run_cmd <= 1'b0;
			halt_cmd <= 1'b0;
			break_cmd <= 1'b0;
			done <= 1'b0;
			run1 <= 1'b0;
			run2 <= 1'b0;
			by_brk <= 1'b0;
		end else begin
			run_cmd <= 1'b0;
			halt_cmd <= 1'b0;
			break_cmd <= 1'b0;
			done <= 1'b0;
			case (state)
				P_IDLE: begin
					if (start) begin
						kind <= stop_kind;
						run_cmd <= 1'b1;
						cnt <= SETTLE;
						state <= P_WAIT1;
					end
				end
				P_WAIT1: begin
					cnt <= cnt - 16'h0001;
					if (cnt == 16'h0001) begin
						run1 <= run_s1;
						halt_cmd <= (kind == pgst_pkg::STOP_HALT);
						break_cmd <= (kind == pgst_pkg::STOP_BREAK);
						cnt <= SETTLE;
						state <= P_WAIT2;
					end
				end
				P_WAIT2: begin
					cnt <= cnt - 16'h0001;
					if (cnt == 16'h0001) begin
						run2 <= run_s1;
						by_brk <= brk_s1;
						state <= P_DONE;
					end
				end
				P_DONE: begin
					done <= 1'b1;
					state <= P_IDLE;
				end
				default: state <= P_IDLE;
			endcase
		end
	end
endmodule

// ==== core/pgst_mem_tester.sv ====
// one fill-and-verify pass over a module memory range
module pgst_mem_tester #(
	parameter int AW = 24
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// pass request
	input wire logic start,
	input wire logic [7:0] pattern,
	input wire logic alt,
	input wire logic hold,
	input wire logic [31:0] hold_cycles,
	input wire logic [AW-1:0] base,
	input wire logic [AW-1:0] last,
	// module memory, read data one cycle after the read strobe
	output logic [AW-1:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic mem_re,
	input wire logic [7:0] mem_rdata,
	// result
	output logic done,
	output logic [6:0] chip_fail,
	output logic fail_any,
	output logic [AW-1:0] fail_addr,
	output logic [7:0] fail_exp,
	output logic [7:0] fail_act
);
	typedef enum logic [2:0] {M_IDLE, M_WRITE, M_HOLD, M_READ, M_DRAIN}
		pgst_mem_t;

	pgst_mem_t state;
	logic [AW-1:0] addr, last_q, base_q, chk_addr;
	logic [7:0] pat_q, chk_exp;
	logic alt_q, hold_q, chk;
	logic [31:0] hcnt;
	wire [7:0] data_now = pat_q ^ ((alt_q && addr[0]) ? 8'hff : 8'h00);
	wire mismatch = chk && (mem_rdata != chk_exp);
	// chips are address slices; the two top chips share one bit
	wire [2:0] chip_idx = chk_addr[AW-1 -: 3];
	wire [2:0] chip_bit = (chip_idx == 3'h7) ? 3'h6 : chip_idx;

	// issue writes then reads, compare one cycle after each read
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= M_IDLE;
			addr <= '0;
			last_q <= '0;
			base_q <= '0;
			pat_q <= 8'h00;
			alt_q <= 1'b0;
			hold_q <= 1'b0;
			hcnt <= 32'h0;
			mem_addr <= '0;
			mem_wdata <= 8'h00;
			mem_we <= 1'b0;
			mem_re <= 1'b0;
			chk <= 1'b0;
			chk_addr <= '0;
			chk_exp <= 8'h00;
			done <= 1'b0;
			chip_fail <= 7'h00;
			fail_any <= 1'b0;
			fail_addr <= '0;
			fail_exp <= 8'h00;
			fail_act <= 8'h00;
		end else begin
			mem_we <= 1'b0;
			mem_re <= 1'b0;
			done <= 1'b0;
			chk <= mem_re;
			chk_addr <= mem_addr;
			chk_exp <= mem_wdata;
			if (mismatch) begin
				chip_fail[chip_bit] <= 1'b1;
				if (!fail_any) begin // keep first failure only
					fail_any <= 1'b1;
					fail_addr <= chk_addr;
					fail_exp <= chk_exp;
					fail_act <= mem_rdata;
				end
			end
			case (state)
				M_IDLE: begin
					if (start) begin
						addr <= base;
						base_q <= base;
						last_q <= last;
						pat_q <= pattern;
						alt_q <= alt;
						hold_q <= hold;
						hcnt <= hold_cycles;
						chip_fail <= 7'h00;
						fail_any <= 1'b0;
						state <= M_WRITE;
					end
				end
				M_WRITE: begin
					mem_we <= 1'b1;
					mem_addr <= addr;
					mem_wdata <= data_now;
					addr <= addr + 1'b1;
					if (addr == last_q) begin
						addr <= base_q;
						state <= hold_q ? M_HOLD : M_READ;
					end
				end
				M_HOLD: begin // retention interval
					hcnt <= hcnt - 32'h1;
					if (hcnt <= 32'h1) begin
						state <= M_READ;
					end
				end
				M_READ: begin
					mem_re <= 1'b1;
					mem_addr <= addr;
					mem_wdata <= data_now;
					addr <= addr + 1'b1;
					if (addr == last_q) begin
						state <= M_DRAIN;
					end
				end
				M_DRAIN: begin
					if (!mem_re && !chk) begin
						done <= 1'b1;
						state <= M_IDLE;
					end
				end
				default: state <= M_IDLE;
			endcase
		end
	end
endmodule

// ==== core/pgst_top.sv ====
// self-test sequencer for the pattern generator module
// Summary of operation
// - loopback walks ones at one address
// - loopback fail word: address, expected, actual
// - clock test: three modes, run then stop
// - clock codes at 15:12, 11:8, 7:4
// - simple fill zeros, ones, alternating, verify
// - one fail bit per chip, 7/8 share
// - persistence writes, waits long, then verifies
// - marching walking patterns, five passes each
// - marching test excluded from run-all
// - pause codes 1, 2, 3 per failure kind
// - decoder test: run, halt, run, break
// - decoder flags 1,2,4,8 ored in 3:0
module pgst_top #(
	parameter int AW = 24,
	parameter logic [23:0] MEM_LAST = 24'hffffff,
	parameter int PERSIST_CYCLES = pgst_pkg::PERSIST_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// module memory under test
	output logic [AW-1:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic mem_re,
	input wire logic [7:0] mem_rdata,
	// clock mode, pause pattern and run/halt control
	output logic [1:0] clk_mode_sel,
	output logic [1:0] pause_event_sel,
	output logic [1:0] pause_mode,
	output logic run_cmd,
	output logic halt_cmd,
	output logic break_cmd,
	input wire logic module_running,
	input wire logic stopped_by_break
);
	typedef enum logic [2:0] {S_IDLE, S_PICK, S_MGO, S_MWAIT, S_PGO,
		S_PWAIT, S_ADV} pgst_state_t;

	// ***************************************************************
	// elaboration checks
	// ***************************************************************
	if (AW < 3 || AW > 24) begin : g_bad_aw
		$error("address width must be 3 to 24");
	end
	if (PERSIST_CYCLES < 1) begin : g_bad_hold
		$error("retention interval must be at least one cycle");
	end

	// ***************************************************************
	// state
	// ***************************************************************
	pgst_state_t state;
	logic [2:0] cur, sel;
	logic all_mode, done, loop_seen;
	logic [3:0] step;
	logic [2:0] sub;
	logic [39:0] res_loop;
	logic [15:0] res_clk, res_pause;
	logic [6:0] res_simple, res_pers, res_march;
	logic [3:0] res_dec;

	// sub-block wires
	logic mt_done, mt_fail;
	logic [6:0] mt_chips;
	logic [AW-1:0] mt_faddr;
	logic [7:0] mt_fexp, mt_fact;
	logic pr_done, pr_run1, pr_run2, pr_brk;
	logic sub_last, step_last;

	// ***************************************************************
	// decode
	// ***************************************************************
	wire busy = (state != S_IDLE);
	wire wr_ctrl = reg_wr && (reg_addr == pgst_pkg::OFS_CTRL);
	wire wr_stat = reg_wr && (reg_addr == pgst_pkg::OFS_STATUS);
	wire go = wr_ctrl && reg_wdata[pgst_pkg::CTRL_START_BIT] && !busy;
	wire [2:0] go_sel = reg_wdata[pgst_pkg::CTRL_SEL_LSB +: 3];
	wire is_mem = (cur == pgst_pkg::T_LOOP) || (cur == pgst_pkg::T_SIMPLE)
		|| (cur == pgst_pkg::T_PERSIST) || (cur == pgst_pkg::T_MARCH);
	wire finish = (state == S_ADV) && sub_last && step_last
		&& (!all_mode || cur == pgst_pkg::T_DECODE);

	// per-test sequence lengths
	assign sub_last = (cur == pgst_pkg::T_MARCH) ?
		(sub == 3'(pgst_pkg::MARCH_PASSES - 1)) :
		(cur == pgst_pkg::T_PAUSE) ? (sub == 3'h2) : 1'b1;
	assign step_last =
		(cur == pgst_pkg::T_LOOP) ? (step == 4'h7) :
		(cur == pgst_pkg::T_CLOCK) ? (step == 4'h2) :
		(cur == pgst_pkg::T_SIMPLE) ? (step == 4'h2) :
		(cur == pgst_pkg::T_PERSIST) ? 1'b1 :
		(cur == pgst_pkg::T_MARCH) ? (step == 4'hf) :
		(cur == pgst_pkg::T_PAUSE) ? (step == 4'h3) : (step == 4'h1);
	// run-all skips the marching test, it can run for over ten seconds
	wire [2:0] next_test = (cur == pgst_pkg::T_PERSIST) ?
		pgst_pkg::T_PAUSE : cur + 3'h1;

	// memory pass settings
	wire [7:0] walk = pgst_pkg::PAT_WALK << step[2:0];
	wire [7:0] mt_pat =
		(cur == pgst_pkg::T_LOOP) ? walk :
		(cur == pgst_pkg::T_SIMPLE) ? ((step == 4'h0) ? pgst_pkg::PAT_ZERO :
			(step == 4'h1) ? pgst_pkg::PAT_ONE : pgst_pkg::PAT_ALT) :
		(cur == pgst_pkg::T_PERSIST) ? pgst_pkg::PAT_PERSIST :
		(step[3] ? ~walk : walk);
	wire mt_alt = (cur == pgst_pkg::T_SIMPLE && step == 4'h2)
		|| (cur == pgst_pkg::T_PERSIST);
	wire mt_hold = (cur == pgst_pkg::T_PERSIST);
	wire [AW-1:0] loop_a = pgst_pkg::LOOP_ADDR[AW-1:0];
	wire [AW-1:0] mt_base = (cur == pgst_pkg::T_LOOP) ? loop_a : '0;
	wire [AW-1:0] mt_last = (cur == pgst_pkg::T_LOOP) ? loop_a :
		MEM_LAST[AW-1:0];

	// probe settings: clock test, decoder first run and noevent pause use a halt
	wire pr_kind = ((cur == pgst_pkg::T_CLOCK)
		|| (cur == pgst_pkg::T_PAUSE && sub == 3'h1)
		|| (cur == pgst_pkg::T_DECODE && step == 4'h0)) ?
		pgst_pkg::STOP_HALT : pgst_pkg::STOP_BREAK;

	// clock result: 300 MHz code highest, nibble moves down per mode
	wire [3:0] clk_code = !pr_run1 ? pgst_pkg::CLK_NO_RUN :
		pr_run2 ? pgst_pkg::CLK_NO_STOP : 4'h0;
	wire [4:0] clk_sh = 5'(12 - 4 * int'(step));
	// pause result: event A at bits 3:0 upward to D, first code kept
	wire [4:0] pse_sh = 5'(4 * int'(step));
	wire pse_free = ((res_pause >> pse_sh) & 16'h000f) == 16'h0000;
	wire [3:0] pse_code =
		(sub == 3'h0) ? (pr_run2 ? pgst_pkg::PSE_BRK_NONE : 4'h0) :
		(sub == 3'h1) ? (!pr_run1 ? pgst_pkg::PSE_NOEVENT : 4'h0) :
		(pr_run2 ? pgst_pkg::PSE_ANY : 4'h0);
	// decoder flags, ored together
	wire [3:0] dec_flags = (!pr_run1 ? pgst_pkg::DEC_NO_BREAK : 4'h0)
		| ((pr_run2 && step == 4'h0) ? pgst_pkg::DEC_NO_SWSTOP : 4'h0)
		| ((pr_run2 && step == 4'h1) ? pgst_pkg::DEC_NO_BRKSTOP : 4'h0)
		| ((!pr_run2 && !pr_brk && step == 4'h1) ?
			pgst_pkg::DEC_OTHER : 4'h0);

	// per-test fail flags and overall pass
	wire [6:0] fails = {res_dec != 4'h0, res_pause != 16'h0,
		res_march != 7'h0, res_pers != 7'h0, res_simple != 7'h0,
		res_clk != 16'h0, res_loop != 40'h0};
	wire pass = done && (fails == 7'h00);

	// ***************************************************************
	// sequencer
	// ***************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= S_IDLE;
			cur <= pgst_pkg::T_LOOP;
			all_mode <= 1'b0;
			step <= 4'h0;
			sub <= 3'h0;
			clk_mode_sel <= 2'h0;
			pause_event_sel <= 2'h0;
			pause_mode <= pgst_pkg::PM_NONE;
		end else begin
			case (state)
				S_IDLE: begin
					if (go) begin
						all_mode <= (go_sel == pgst_pkg::T_ALL);
						cur <= (go_sel == pgst_pkg::T_ALL) ?
							pgst_pkg::T_LOOP : go_sel;
						step <= 4'h0;
						sub <= 3'h0;
						state <= S_PICK;
					end
				end
				S_PICK: begin
					// selects move only in their own test, no stray codes
					if (cur == pgst_pkg::T_CLOCK) begin
						clk_mode_sel <= step[1:0];
					end
					if (cur == pgst_pkg::T_PAUSE) begin
						pause_event_sel <= step[1:0];
						pause_mode <= sub[1:0];
					end
					state <= is_mem ? S_MGO : S_PGO;
				end
				S_MGO: state <= S_MWAIT;
				S_MWAIT: state <= mt_done ? S_ADV : S_MWAIT;
				S_PGO: state <= S_PWAIT;
				S_PWAIT: state <= pr_done ? S_ADV : S_PWAIT;
				S_ADV: begin
					state <= S_PICK;
					if (!sub_last) begin
						sub <= sub + 3'h1;
					end else if (!step_last) begin
						sub <= 3'h0;
						step <= step + 4'h1;
					end else if (finish) begin
						state <= S_IDLE;
					end else begin
						sub <= 3'h0;
						step <= 4'h0;
						cur <= next_test;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// result capture, cleared when a run starts
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			res_loop <= 40'h0;
			loop_seen <= 1'b0;
			res_clk <= 16'h0;
			res_simple <= 7'h00;
			res_pers <= 7'h00;
			res_march <= 7'h00;
			res_pause <= 16'h0;
			res_dec <= 4'h0;
		end else if (go) begin
			res_loop <= 40'h0;
			loop_seen <= 1'b0;
			res_clk <= 16'h0;
			res_simple <= 7'h00;
			res_pers <= 7'h00;
			res_march <= 7'h00;
			res_pause <= 16'h0;
			res_dec <= 4'h0;
		end else if (state == S_MWAIT && mt_done) begin
			case (cur)
				pgst_pkg::T_LOOP: begin
					if (mt_fail && !loop_seen) begin
						loop_seen <= 1'b1;
						res_loop <= {24'(mt_faddr), mt_fexp,
							mt_fact};
					end
				end
				pgst_pkg::T_SIMPLE: res_simple <= res_simple | mt_chips;
				pgst_pkg::T_PERSIST: res_pers <= res_pers | mt_chips;
				pgst_pkg::T_MARCH: res_march <= res_march | mt_chips;
				default: res_dec <= res_dec;
			endcase
		end else if (state == S_PWAIT && pr_done) begin
			case (cur)
				pgst_pkg::T_CLOCK: res_clk <= res_clk
					| (16'(clk_code) << clk_sh);
				pgst_pkg::T_PAUSE: begin
					if (pse_free) begin
						res_pause <= res_pause
							| (16'(pse_code) << pse_sh);
					end
				end
				default: res_dec <= res_dec | dec_flags;
			endcase
		end
	end

	// ***************************************************************
	// register port
	// ***************************************************************
	// done is set by the sequencer and wins over a software clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			done <= 1'b0;
			sel <= pgst_pkg::RST_SEL;
		end else begin
			if (wr_ctrl && !busy) begin
				sel <= go_sel;
			end
			if (finish) begin
				done <= 1'b1;
			end else if (go || (wr_stat &&
				reg_wdata[pgst_pkg::STAT_DONE_BIT])) begin
				done <= 1'b0;
			end
		end
	end

	// read mux, data one cycle after the strobe, unmapped reads zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		case (reg_addr)
			pgst_pkg::OFS_CTRL: rd_mux[pgst_pkg::CTRL_SEL_LSB +: 3] = sel;
			pgst_pkg::OFS_STATUS: begin
				rd_mux[pgst_pkg::STAT_BUSY_BIT] = busy;
				rd_mux[pgst_pkg::STAT_DONE_BIT] = done;
				rd_mux[pgst_pkg::STAT_PASS_BIT] = pass;
				rd_mux[pgst_pkg::STAT_FAIL_LSB +: 7] = fails;
			end
			pgst_pkg::OFS_LOOP_LO: rd_mux = res_loop[31:0];
			pgst_pkg::OFS_LOOP_HI: rd_mux[7:0] = res_loop[39:32];
			pgst_pkg::OFS_CLOCK: rd_mux[15:0] = res_clk;
			pgst_pkg::OFS_SIMPLE: rd_mux[6:0] = res_simple;
			pgst_pkg::OFS_PERSIST: rd_mux[6:0] = res_pers;
			pgst_pkg::OFS_MARCH: rd_mux[6:0] = res_march;
			pgst_pkg::OFS_PAUSE: rd_mux[15:0] = res_pause;
			pgst_pkg::OFS_DECODE: rd_mux[3:0] = res_dec;
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
		end
	end

	// ***************************************************************
	// sub-blocks
	// ***************************************************************
	pgst_mem_tester #(.AW(AW)) u_mem (
		.sys_clk(sys_clk), .rst(rst), .start(state == S_MGO),
		.pattern(mt_pat), .alt(mt_alt), .hold(mt_hold),
		.hold_cycles(32'(PERSIST_CYCLES)), .base(mt_base),
		.last(mt_last), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
		.done(mt_done), .chip_fail(mt_chips), .fail_any(mt_fail),
		.fail_addr(mt_faddr), .fail_exp(mt_fexp), .fail_act(mt_fact)
	);

	pgst_run_probe u_probe (
		.sys_clk(sys_clk), .rst(rst), .start(state == S_PGO),
		.stop_kind(pr_kind), .run_cmd(run_cmd), .halt_cmd(halt_cmd),
		.break_cmd(break_cmd), .module_running(module_running),
		.stopped_by_break(stopped_by_break), .done(pr_done),
		.run1(pr_run1), .run2(pr_run2), .by_brk(pr_brk)
	);
endmodule

// ==== sim/pgst_mem_model.sv ====
// module memory and run/halt control facing the self-test block
module pgst_mem_model #(
	parameter int AW = 5
) (
	// clock
	input wire logic sys_clk,
	// module memory
	input wire logic [AW-1:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_we,
	input wire logic mem_re,
	output logic [7:0] mem_rdata,
	// run/halt control
	input wire logic run_cmd,
	input wire logic halt_cmd,
	input wire logic break_cmd,
	output logic module_running,
	output logic stopped_by_break,
	// fault injection from the bench
	input wire logic [AW-1:0] flt_a,
	input wire logic [7:0] flt_m,
	input wire logic no_run,
	input wire logic no_stop
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [2**AW];
	wire logic [7:0] flip = (mem_addr == flt_a) ? flt_m : 8'h00;
	initial begin
		mem_rdata = 8'h00;
		module_running = 1'b0;
		stopped_by_break = 1'b0;
	end
	// data one cycle late; idle bus toggles so stale data never matches
	always @(posedge sys_clk) begin
		if (mem_we) mem[mem_addr] <= mem_wdata;
		mem_rdata <= mem_re ? (mem[mem_addr] ^ flip) : ~mem_rdata;
	end
	// run/halt; a fault pins the module in one state; a run clears the
	// stop cause, only a running module that really stops records one
	always @(posedge sys_clk) begin
		if (run_cmd && !no_run) module_running <= 1'b1;
		if ((halt_cmd || break_cmd) && !no_stop) module_running <= 1'b0;
		if (run_cmd) stopped_by_break <= 1'b0;
		if ((halt_cmd || break_cmd) && module_running && !no_stop)
			stopped_by_break <= break_cmd;
	end
endmodule

// ==== sim/pgst_props.sv ====
// port-level checks of the self-test block
module pgst_props #(
	parameter int AW = 24,
	parameter logic [23:0] MEM_LAST = 24'hffffff
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register port
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// memory and run control
	input wire logic [AW-1:0] mem_addr,
	input wire logic mem_we,
	input wire logic mem_re,
	input wire logic [1:0] clk_mode_sel,
	input wire logic [1:0] pause_event_sel,
	input wire logic [1:0] pause_mode,
	input wire logic run_cmd,
	input wire logic halt_cmd,
	input wire logic break_cmd
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// a probe opens with a lone run pulse, then waits to settle
	sequence s_run;
		run_cmd ##1 !run_cmd;
	endsequence
	sequence s_quiet;
		!run_cmd && !halt_cmd && !break_cmd;
	endsequence
	a_no_rw_mix: assert property (!(mem_we && mem_re))
		else $error("memory read and write in one cycle");
	a_addr_in_range: assert property ((mem_we || mem_re) |->
		mem_addr <= MEM_LAST[AW-1:0]) else $error("address past end");
	a_one_cmd: assert property (
		$onehot0({run_cmd, halt_cmd, break_cmd}))
		else $error("two run control pulses at once");
	a_run_pulse: assert property (run_cmd |-> s_run)
		else $error("run pulse too long");
	a_settle_wait: assert property (s_run |=> s_quiet[*8])
		else $error("stop issued before settle");
	a_clk_mode: assert property (clk_mode_sel != 2'h3)
		else $error("illegal clock mode");
	a_pause_mode: assert property (pause_mode != 2'h3)
		else $error("illegal pause mode");
	a_evt_hold: assert property (s_run |=>
		($stable(pause_event_sel))[*8])
		else $error("pause event changed during a probe");
	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the self-test block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AW = 5;
	localparam logic [31:0] CK [3] = '{32'h0, 32'h1110, 32'h2220};
	localparam logic [31:0] PT [3] = '{32'h0, 32'h2222, 32'h1111};
	localparam logic [31:0] DT [3] = '{32'h0, 32'h9, 32'h6};
	logic sys_clk, rst, reg_wr, reg_rd, mem_we, mem_re, rd_d;
	logic run_cmd, halt_cmd, break_cmd, module_running, stopped_by_break;
	logic no_run, no_stop;
	logic [7:0] reg_addr, mem_wdata, mem_rdata, flt_m;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [AW-1:0] mem_addr, flt_a;
	logic [1:0] clk_mode_sel, pause_event_sel, pause_mode;
	logic [6:0] bit_i;
	logic [32:0] x;
	logic [32:0] q[$];
	int n_fail, total_checks;
	pgst_top #(.AW(AW), .MEM_LAST(24'h00001f), .PERSIST_CYCLES(20)) dut (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
		.clk_mode_sel(clk_mode_sel), .pause_event_sel(pause_event_sel),
		.pause_mode(pause_mode), .run_cmd(run_cmd), .halt_cmd(halt_cmd),
		.break_cmd(break_cmd), .module_running(module_running),
		.stopped_by_break(stopped_by_break));
	pgst_mem_model #(.AW(AW)) u_mem (
		.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
		.run_cmd(run_cmd), .halt_cmd(halt_cmd), .break_cmd(break_cmd),
		.module_running(module_running), .stopped_by_break(stopped_by_break),
		.flt_a(flt_a), .flt_m(flt_m), .no_run(no_run), .no_stop(no_stop));
	// free running clock
	always #2 sys_clk = ~sys_clk;
	task automatic cmp(input logic [31:0] e, input logic [31:0] a);
		total_checks++;
		if (a !== e) begin
			n_fail++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// every read notes its expectation; c marks the ones to compare
	task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		q.push_back({c, e});
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		v = reg_rdata;
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		rd(a, 1'b1, e);
	endtask
	// start a test, poll for done, then check the status word
	task automatic run_t(input logic [2:0] s, input logic [6:0] f, input logic c);
		int n;
		wr(pgst_pkg::OFS_CTRL, {28'h0, s, 1'b1});
		n = 0;
		do begin
			rd(pgst_pkg::OFS_STATUS, 1'b0, 32'h0);
			n++;
		end while (v[1] !== 1'b1 && n < 30000);
		if (v[1] !== 1'b1) n_fail++;
		if (c) chk(pgst_pkg::OFS_STATUS,
			{21'h0, f, 1'b0, f == 7'h0, 2'b10});
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// monitor: read data stand in the cycle after the strobe only
	always @(posedge sys_clk) rd_d <= reg_rd;
	always @(negedge sys_clk) begin
		if (rd_d && q.size() > 0) begin
			x = q.pop_front();
			if (x[32]) cmp(x[31:0], reg_rdata);
		end
	end
	// watchdog, well past the expected run length
	initial begin
		#380000;
		n_fail++;
		wrap_up;
	end
	// main sequence
	initial begin
		sys_clk = 0;
		rst = 1;
		{reg_wr, reg_rd, no_run, no_stop} = '0;
		{reg_addr, reg_wdata, flt_a, flt_m} = '0;
		n_fail = 0;
		total_checks = 0;
		void'($urandom(32'h2ef7c87c));
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		chk(pgst_pkg::OFS_STATUS, 32'h0);
		chk(8'hfc, 32'h0);
		run_t(pgst_pkg::T_LOOP, 7'h00, 1'b1);
		chk(pgst_pkg::OFS_LOOP_LO, 32'h0);
		flt_m <= 8'h08;
		run_t(pgst_pkg::T_LOOP, 7'h01, 1'b1);
		chk(pgst_pkg::OFS_LOOP_LO, 32'h0000_0109);
		chk(pgst_pkg::OFS_LOOP_HI, 32'h0);
		flt_a <= AW'($urandom);
		flt_m <= 8'h01 << ($urandom % 8);
		@(posedge sys_clk);
		bit_i = 7'h01 << ((flt_a[4:2] == 3'h7) ? 3'h6 : flt_a[4:2]);
		// simple, persistence and marching each see the same bad cell
		for (int i = 0; i < 3; i++) begin
			run_t(3'(pgst_pkg::T_SIMPLE + i), 7'h04 << i, 1'b1);
			chk(8'(pgst_pkg::OFS_SIMPLE + 4 * i), {25'h0, bit_i});
		end
		run_t(pgst_pkg::T_ALL, 7'h00, 1'b0);
		chk(pgst_pkg::OFS_MARCH, 32'h0);
		chk(pgst_pkg::OFS_SIMPLE, {25'h0, bit_i});
		flt_m <= 8'h00;
		// healthy module, then one that never runs, then one that never stops
		for (int m = 0; m < 3; m++) begin
			no_run <= (m == 1);
			no_stop <= (m == 2);
			run_t(pgst_pkg::T_CLOCK, (m > 0) ? 7'h02 : 7'h00, 1'b1);
			chk(pgst_pkg::OFS_CLOCK, CK[m]);
			run_t(pgst_pkg::T_PAUSE, (m > 0) ? 7'h20 : 7'h00, 1'b1);
			chk(pgst_pkg::OFS_PAUSE, PT[m]);
			run_t(pgst_pkg::T_DECODE, (m > 0) ? 7'h40 : 7'h00, 1'b1);
			chk(pgst_pkg::OFS_DECODE, DT[m]);
		end
		wrap_up;
	end
endmodule
bind pgst_top pgst_props #(.AW(AW), .MEM_LAST(MEM_LAST)) u_props (
	.sys_clk(sys_clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.mem_addr(mem_addr), .mem_we(mem_we), .mem_re(mem_re),
	.clk_mode_sel(clk_mode_sel), .pause_event_sel(pause_event_sel),
	.pause_mode(pause_mode),
	.run_cmd(run_cmd), .halt_cmd(halt_cmd), .break_cmd(break_cmd));
